// *** hdl/flash_host_defs.svh ***
// Purpose: constants for the flash command host controller
// Assumes: 40 MHz clock, byte-wide flash with 20 address bits
// Notes: timing counts rounded up to whole clock cycles
// Operation
// - AA, 55, 90 enters identification mode
// - read offset 02 gives sector protection
// - program: unlock, unlock, A0, address plus data
// - erase: six cycles, 10 chip, 30 sector
// - F0 returns flash to read mode
// - read with select, output enable low
// - writes hold write and select low, output high
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH

`define CLK_PERIOD_NS 25
`define T_ACCESS_NS 70
`define T_ACCESS_CYC ((`T_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_WPULSE_NS 35
`define T_WPULSE_CYC ((`T_WPULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_RESET_NS 500
`define T_RESET_CYC ((`T_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define UNLOCK1_ADDR 20'h00AAA
`define UNLOCK2_ADDR 20'h00555
`define UNLOCK1_DATA 8'hAA
`define UNLOCK2_DATA 8'h55
`define CMD_ID 8'h90
`define CMD_PROGRAM 8'hA0
`define CMD_ERASE_SETUP 8'h80
`define CMD_CHIP_ERASE 8'h10
`define CMD_SECTOR_ERASE 8'h30
`define CMD_SUSPEND 8'hB0
`define CMD_RESUME 8'h30
`define CMD_READ_RESET 8'hF0
`define ID_MAKER_ADDR 20'h00000
`define ID_PART_ADDR 20'h00001
`define ID_PROTECT_LOW 20'h00002
`define SECTOR_LSB 13

`endif

// *** hdl/flash_host_pkg.sv ***
// Purpose: types for the flash command host controller
// Assumes: used with flash_host_defs.svh
// Notes: op codes select the issued sequence
package flash_host_pkg;
	typedef enum logic [3:0]
	{
		OP_READ,
		OP_RESET_CMD,
		OP_ID_READ,
		OP_PROTECT_READ,
		OP_PROGRAM,
		OP_CHIP_ERASE,
		OP_SECTOR_ERASE,
		OP_SUSPEND,
		OP_RESUME,
		OP_HW_RESET
	} op_t;

	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_WSETUP,
		ST_WPULSE,
		ST_WGAP,
		ST_RPULSE,
		ST_RSTPULSE,
		ST_DONE
	} state_t;
endpackage

// *** hdl/flash_host.sv ***
// Purpose: host side controller issuing flash command sequences over pins
// Assumes: flash pins synchronous to clk_i; one request at a time
// Notes: busy_o stays high from accept to done_o
`timescale 1ns/1ps
`include "flash_host_defs.svh"

module flash_host
	import flash_host_pkg::*;
#(
	parameter int ADDR_W = 20
)
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic req_i,
	input wire op_t op_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [7:0] data_i,
	input wire logic [7:0] flash_dq_i,
	input wire logic flash_ready_busy_out_i,
	output logic busy_o,
	output logic done_o,
	output logic [7:0] rdata_o,
	output logic flash_ready_o,
	output logic [ADDR_W-1:0] flash_addr_o,
	output logic [7:0] flash_dq_o,
	output logic flash_dq_oe_o,
	output logic flash_ce_n_o,
	output logic flash_oe_n_o,
	output logic flash_we_n_o,
	output logic flash_reset_n_o
);
	// ****************************************
	// sequence table
	// ****************************************
	state_t state_q, state_d;
	op_t op_q, op_d;
	logic [2:0] step_q, step_d;
	logic [2:0] nsteps;
	logic [7:0] cnt_q, cnt_d;
	logic [ADDR_W-1:0] uaddr_q, uaddr_d;
	logic [7:0] udata_q, udata_d;
	logic [ADDR_W-1:0] cyc_addr;
	logic [7:0] cyc_data;
	logic [7:0] rdata_d;
	logic busy_d, done_d, rdy_q, rdy_d;
	logic [ADDR_W-1:0] fa_d;
	logic [7:0] fdq_d;
	logic foe_d, ce_d, oe_d, we_d, rst_d;
	logic [ADDR_W-1:0] sec_mask;

	assign sec_mask = {{(ADDR_W-`SECTOR_LSB){1'b1}}, {`SECTOR_LSB{1'b0}}};

	always_comb
	begin
		unique case (op_q)
			OP_ID_READ, OP_PROTECT_READ: nsteps = 3'd3;
			OP_PROGRAM: nsteps = 3'd4;
			OP_CHIP_ERASE, OP_SECTOR_ERASE: nsteps = 3'd6;
			OP_RESET_CMD, OP_SUSPEND, OP_RESUME: nsteps = 3'd1;
			default: nsteps = 3'd0;
		endcase
	end

	always_comb
	begin
		cyc_addr = ADDR_W'(`UNLOCK1_ADDR);
		cyc_data = `UNLOCK1_DATA;
		unique case (step_q)
			3'd0, 3'd3:
			begin
				cyc_addr = ADDR_W'(`UNLOCK1_ADDR);
				cyc_data = `UNLOCK1_DATA;
			end
			3'd1, 3'd4:
			begin
				cyc_addr = ADDR_W'(`UNLOCK2_ADDR);
				cyc_data = `UNLOCK2_DATA;
			end
			3'd2:
			begin
				cyc_addr = ADDR_W'(`UNLOCK1_ADDR);
				if (op_q == OP_PROGRAM)
					cyc_data = `CMD_PROGRAM;
				else if (op_q == OP_CHIP_ERASE || op_q == OP_SECTOR_ERASE)
					cyc_data = `CMD_ERASE_SETUP;
				else
					cyc_data = `CMD_ID;
			end
			default:
			begin
				cyc_addr = uaddr_q;
				cyc_data = udata_q;
			end
		endcase
		if (op_q == OP_PROGRAM && step_q == 3'd3)
		begin
			cyc_addr = uaddr_q;
			cyc_data = udata_q;
		end
		if (op_q == OP_RESET_CMD)
			cyc_data = `CMD_READ_RESET;
		else if (op_q == OP_SUSPEND)
			cyc_data = `CMD_SUSPEND;
		else if (op_q == OP_RESUME)
			cyc_data = `CMD_RESUME;
		if (nsteps == 3'd1)
			cyc_addr = uaddr_q;
	end

	// ****************************************
	// pin sequencer
	// ****************************************
	always_comb
	begin
		state_d = state_q;
		op_d = op_q;
		step_d = step_q;
		cnt_d = cnt_q;
		uaddr_d = uaddr_q;
		udata_d = udata_q;
		rdata_d = rdata_o;
		busy_d = busy_o;
		done_d = 1'b0;
		rdy_d = flash_ready_busy_out_i;
		fa_d = flash_addr_o;
		fdq_d = flash_dq_o;
		foe_d = flash_dq_oe_o;
		ce_d = flash_ce_n_o;
		oe_d = flash_oe_n_o;
		we_d = flash_we_n_o;
		rst_d = flash_reset_n_o;
		unique case (state_q)
			ST_IDLE:
			begin
				if (req_i)
				begin
					op_d = op_i;
					step_d = 3'd0;
					busy_d = 1'b1;
					uaddr_d = addr_i;
					udata_d = data_i;
					if (op_i == OP_CHIP_ERASE)
						udata_d = `CMD_CHIP_ERASE;
					else if (op_i == OP_SECTOR_ERASE)
					begin
						udata_d = `CMD_SECTOR_ERASE;
						uaddr_d = addr_i & sec_mask;
					end
					if (op_i == OP_HW_RESET)
					begin
						rst_d = 1'b0;
						cnt_d = 8'(`T_RESET_CYC);
						state_d = ST_RSTPULSE;
					end
					else if (op_i == OP_READ)
					begin
						fa_d = addr_i;
						ce_d = 1'b0;
						oe_d = 1'b0;
						cnt_d = 8'(`T_ACCESS_CYC);
						state_d = ST_RPULSE;
					end
					else
						state_d = ST_WSETUP;
				end
			end
			ST_WSETUP:
			begin
				fa_d = cyc_addr;
				fdq_d = cyc_data;
				foe_d = 1'b1;
				oe_d = 1'b1;
				ce_d = 1'b0;
				we_d = 1'b0;
				cnt_d = 8'(`T_WPULSE_CYC);
				state_d = ST_WPULSE;
			end
			ST_WPULSE:
			begin
				if (cnt_q <= 8'd1)
				begin
					we_d = 1'b1;
					ce_d = 1'b1;
					state_d = ST_WGAP;
				end
				else
					cnt_d = cnt_q - 8'd1;
			end
			ST_WGAP:
			begin
				foe_d = 1'b0;
				step_d = step_q + 3'd1;
				if (step_q + 3'd1 < nsteps)
					state_d = ST_WSETUP;
				else if (op_q == OP_ID_READ || op_q == OP_PROTECT_READ)
				begin
					fa_d = (op_q == OP_PROTECT_READ)
						? ((uaddr_q & sec_mask) | ADDR_W'(`ID_PROTECT_LOW))
						: uaddr_q;
					ce_d = 1'b0;
					oe_d = 1'b0;
					cnt_d = 8'(`T_ACCESS_CYC);
					state_d = ST_RPULSE;
				end
				else
					state_d = ST_DONE;
			end
			ST_RPULSE:
			begin
				if (cnt_q <= 8'd1)
				begin
					rdata_d = flash_dq_i;
					ce_d = 1'b1;
					oe_d = 1'b1;
					state_d = ST_DONE;
				end
				else
					cnt_d = cnt_q - 8'd1;
			end
			ST_RSTPULSE:
			begin
				if (cnt_q <= 8'd1)
				begin
					rst_d = 1'b1;
					state_d = ST_DONE;
				end
				else
					cnt_d = cnt_q - 8'd1;
			end
			ST_DONE:
			begin
				busy_d = 1'b0;
				done_d = 1'b1;
				state_d = ST_IDLE;
			end
			default:
				state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			state_q <= ST_IDLE;
			op_q <= OP_READ;
			step_q <= 3'd0;
			cnt_q <= 8'h00;
			uaddr_q <= '0;
			udata_q <= 8'h00;
			rdata_o <= 8'h00;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			rdy_q <= 1'b0;
			flash_addr_o <= '0;
			flash_dq_o <= 8'h00;
			flash_dq_oe_o <= 1'b0;
			flash_ce_n_o <= 1'b1;
			flash_oe_n_o <= 1'b1;
			flash_we_n_o <= 1'b1;
			flash_reset_n_o <= 1'b1;
		end
		else
		begin
			state_q <= state_d;
			op_q <= op_d;
			step_q <= step_d;
			cnt_q <= cnt_d;
			uaddr_q <= uaddr_d;
			udata_q <= udata_d;
			rdata_o <= rdata_d;
			busy_o <= busy_d;
			done_o <= done_d;
			rdy_q <= rdy_d;
			flash_addr_o <= fa_d;
			flash_dq_o <= fdq_d;
			flash_dq_oe_o <= foe_d;
			flash_ce_n_o <= ce_d;
			flash_oe_n_o <= oe_d;
			flash_we_n_o <= we_d;
			flash_reset_n_o <= rst_d;
		end
	end

	assign flash_ready_o = rdy_q;
endmodule

// *** verification/flash_host_chk.sv ***
// Purpose: pin protocol checks on flash_host
// Assumes: bound to every flash_host instance
// Notes: checks disabled while rst_n_i low
`timescale 1ns/1ps
module flash_host_chk #(
	parameter int ADDR_W = 20
)
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [ADDR_W-1:0] flash_addr_o,
	input wire logic [7:0] flash_dq_o,
	input wire logic flash_dq_oe_o,
	input wire logic flash_ce_n_o,
	input wire logic flash_oe_n_o,
	input wire logic flash_we_n_o,
	input wire logic flash_reset_n_o
);
	// ****
	// assertions
	// ****
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_write_pins: assert property (!flash_we_n_o |->
		!flash_ce_n_o && flash_oe_n_o) else $error("write without select");
	a_read_pins: assert property (!flash_oe_n_o |->
		flash_we_n_o && !flash_ce_n_o && !flash_dq_oe_o) else $error("bad read pins");
	a_we_width: assert property ($fell(flash_we_n_o) |->
		##1 !flash_we_n_o ##1 flash_we_n_o) else $error("write pulse width");
	a_strobe_hold: assert property (!flash_we_n_o && !$fell(flash_we_n_o) |->
		$stable(flash_addr_o) && $stable(flash_dq_o)) else $error("bus moved in pulse");
	a_dq_drive: assert property (!flash_we_n_o |-> flash_dq_oe_o)
		else $error("data not driven");
	a_dq_release: assert property ($rose(flash_we_n_o) |=> !flash_dq_oe_o)
		else $error("data not released");
	a_reset_quiet: assert property (!flash_reset_n_o |->
		flash_we_n_o && flash_oe_n_o) else $error("strobe in reset");
	a_reset_width: assert property ($fell(flash_reset_n_o) |->
		!flash_reset_n_o [*8]) else $error("reset pulse short");
	cover property ($fell(flash_we_n_o));
	cover property ($fell(flash_oe_n_o));
	cover property ($fell(flash_reset_n_o));
endmodule

bind flash_host flash_host_chk #(.ADDR_W(ADDR_W)) chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.flash_addr_o(flash_addr_o), .flash_dq_o(flash_dq_o), .flash_dq_oe_o(flash_dq_oe_o),
	.flash_ce_n_o(flash_ce_n_o), .flash_oe_n_o(flash_oe_n_o), .flash_we_n_o(flash_we_n_o),
	.flash_reset_n_o(flash_reset_n_o));

// *** verification/flash_model.sv ***
// Purpose: behavioural byte flash for the host bench
// Assumes: pins sampled on clk_i; array folded to 256 bytes
// Notes: busy times shortened
`timescale 1ns/1ps
`include "flash_host_defs.svh"
module flash_model #(
	parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
	parameter logic [7:0] PART_CODE = 8'hA5, // arbitrary value
	parameter logic [127:0] PROT = 128'h20
)
(
	input wire logic clk_i,
	input wire logic [19:0] addr_i,
	input wire logic [7:0] dq_i,
	input wire logic ce_n_i,
	input wire logic oe_n_i,
	input wire logic we_n_i,
	input wire logic reset_n_i,
	output logic [7:0] dq_o = 8'h00,
	output logic ready_busy_out_o = 1'b1
);
	// ****
	// command decoder
	// ****
	logic [7:0] mem [256];
	logic [19:0] la = 0;
	logic [7:0] k = 0;
	int n = 0;
	int t = 0;
	logic er = 0, sp = 0, id = 0, tg = 0, pw = 1, po = 1;
	initial foreach (mem[i]) mem[i] = 8'hFF;
	function automatic logic [7:0] rv();
		if (id)
			return addr_i[1] ? {7'h00, PROT[addr_i[19:13]]} :
				(addr_i[0] ? PART_CODE : MAKER_CODE);
		if (er && !sp)
			return {1'b0, tg, 6'h00};
		return mem[addr_i[7:0]];
	endfunction
	task automatic cmd(input logic [7:0] d);
		if (t > 0 && !er)
			n = 0;
		else if (er && !sp)
			sp = (d == `CMD_SUSPEND);
		else if (er && d == `CMD_RESUME && n != 5)
			sp = 0;
		else if (n == 3 && k == `CMD_PROGRAM)
		begin
			mem[la[7:0]] = d;
			t = 60;
			n = 0;
		end
		else if (n == 5 && (d == `CMD_CHIP_ERASE || d == `CMD_SECTOR_ERASE))
		begin
			er = 1;
			t = 300;
			n = 0;
			if (d == `CMD_CHIP_ERASE)
				foreach (mem[i]) mem[i] = 8'hFF;
		end
		else if (n == 2 && la == `UNLOCK1_ADDR && (d == `CMD_ID || d == `CMD_PROGRAM
			|| d == `CMD_ERASE_SETUP))
		begin
			k = d;
			id = (d == `CMD_ID);
			n = id ? 0 : 3;
		end
		else if (n % 3 == 0 && la == `UNLOCK1_ADDR && d == `UNLOCK1_DATA
			|| n % 3 == 1 && la == `UNLOCK2_ADDR && d == `UNLOCK2_DATA)
			n++;
		else
		begin
			n = 0;
			id = 0;
		end
	endtask
	always @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			{n, t} = 0;
			{er, sp, id} = 0;
		end
		else
		begin
			if (t > 0 && !sp)
				t = t - 1;
			if (t == 0)
				er = 0;
			if (pw && !we_n_i && !ce_n_i)
				la = addr_i;
			if (!pw && we_n_i)
				cmd(dq_i);
			if (po && !oe_n_i)
				tg = !tg;
		end
		dq_o <= (!ce_n_i && !oe_n_i && reset_n_i) ? rv() : ~dq_o;
		pw = we_n_i;
		po = oe_n_i;
		ready_busy_out_o <= (t == 0);
	end
endmodule

// *** verification/tb_flash_host.sv ***
// Purpose: self-checking bench for flash_host
// Assumes: flash_model on the pins
// Notes: inputs change 2 ns after rising edge
`timescale 1ns/1ps
module tb_flash_host
	import flash_host_pkg::*;
;
	// ****
	// bench
	// ****
	localparam logic [7:0] MK = 8'h5A;
	localparam logic [7:0] PT = 8'hA5;
	logic clk_i = 0, rst_n_i = 0, req_i = 0;
	op_t op_i = OP_READ;
	logic [19:0] addr_i = 0, fa;
	logic [7:0] data_i = 0, r1, rd_q, fdo, mdq;
	logic busy, done, frdy, foe, ce, oe, we, rn, mrb;
	wire logic [7:0] bus = foe ? fdo : mdq;
	int bad_count = 0, checks = 0;
	initial forever #12.5 clk_i = ~clk_i;
	flash_host dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .op_i(op_i),
		.addr_i(addr_i), .data_i(data_i), .flash_dq_i(bus), .flash_ready_busy_out_i(mrb),
		.busy_o(busy), .done_o(done), .rdata_o(rd_q), .flash_ready_o(frdy),
		.flash_addr_o(fa), .flash_dq_o(fdo), .flash_dq_oe_o(foe), .flash_ce_n_o(ce),
		.flash_oe_n_o(oe), .flash_we_n_o(we), .flash_reset_n_o(rn));
	flash_model #(.MAKER_CODE(MK), .PART_CODE(PT)) fm (.clk_i(clk_i), .addr_i(fa),
		.dq_i(bus), .ce_n_i(ce), .oe_n_i(oe), .we_n_i(we), .reset_n_i(rn),
		.dq_o(mdq), .ready_busy_out_o(mrb));
	task end_sim();
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task op(input op_t o, input logic [19:0] a, input logic [7:0] d);
		int i;
		@(posedge clk_i) #2;
		op_i = o;
		addr_i = a;
		data_i = d;
		req_i = 1;
		@(posedge clk_i) #2;
		req_i = 0;
		chk({7'h00, busy}, 8'h01);
		for (i = 0; i < 400 && done !== 1'b1; i++) @(posedge clk_i) #1;
		if (i == 400)
			chk_tmo();
		chk({7'h00, busy}, 8'h00);
	endtask
	task chk_tmo();
		bad_count++;
		end_sim();
	endtask
	task wrdy();
		int i;
		for (i = 0; i < 1000 && frdy !== 1'b1; i++) @(posedge clk_i) #1;
		if (i == 1000)
			chk_tmo();
	endtask
	task s_prog();
		op(OP_PROGRAM, 20'h00034, 8'h12);
		op(OP_PROGRAM, 20'h00035, 8'h77);
		wrdy();
		op(OP_READ, 20'h00035, 8'h00);
		chk(rd_q, 8'hFF);
		op(OP_READ, 20'h00034, 8'h00);
		chk(rd_q, 8'h12);
	endtask
	task s_id();
		op(OP_ID_READ, 20'h00000, 8'h00);
		chk(rd_q, MK);
		op(OP_ID_READ, 20'h00001, 8'h00);
		chk(rd_q, PT);
		op(OP_PROTECT_READ, 20'h0BFF2, 8'h00);
		chk(rd_q, 8'h01);
		op(OP_PROTECT_READ, 20'h0C002, 8'h00);
		chk(rd_q, 8'h00);
		op(OP_RESET_CMD, 20'h00000, 8'h00);
		op(OP_READ, 20'h00034, 8'h00);
		chk(rd_q, 8'h12);
	endtask
	task s_erase();
		op(OP_SECTOR_ERASE, 20'h02000, 8'h00);
		op(OP_READ, 20'h00034, 8'h00);
		r1 = rd_q;
		op(OP_READ, 20'h00034, 8'h00);
		chk(r1 ^ rd_q, 8'h40);
		op(OP_PROGRAM, 20'h00036, 8'h55);
		op(OP_SUSPEND, 20'h00000, 8'h00);
		op(OP_READ, 20'h00034, 8'h00);
		chk(rd_q, 8'h12);
		op(OP_READ, 20'h00036, 8'h00);
		chk(rd_q, 8'hFF);
		op(OP_RESUME, 20'h00000, 8'h00);
		wrdy();
		chk({7'h00, frdy}, 8'h01);
	endtask
	task s_misc();
		op(OP_SUSPEND, 20'h00000, 8'h00);
		op(OP_READ, 20'h00034, 8'h00);
		chk(rd_q, 8'h12);
		op(OP_CHIP_ERASE, 20'h00000, 8'h00);
		op(OP_HW_RESET, 20'h00000, 8'h00);
		@(posedge clk_i) #1;
		chk({7'h00, frdy}, 8'h01);
		op(OP_READ, 20'h00034, 8'h00);
		chk(rd_q, 8'hFF);
	endtask
	initial
	begin
		repeat (12) @(posedge clk_i);
		#2 rst_n_i = 1;
		s_prog();
		s_id();
		s_erase();
		s_misc();
		end_sim();
	end
endmodule
